// ### common/flviu_pkg.sv
// constants, carriers and register map of the four-level vectored interrupt unit
// assumes one system clock; cpu sequencer and timers sit on the same clock
//
// Overview of operation
// - timer2 overflow sets its flag unless serial clocking uses timer2; software clears
// - falling t2 pin edge with external enable sets external flag; no request in up/down
// - aux control holds enable, priority-low, type and flag for ext2 and ext3
// - ext2/ext3 edge flags clear in hardware when their service starts
// - level = {not high bit, not low bit}: 1,1 gives 0 (top), 0,0 gives 3
// - only a strictly higher level pre-empts; top level is never pre-empted
// - among pending levels the higher priority level is serviced first
// - equal levels resolved by fixed order ext0,t0,ext1,t1,serial,t2,ext2,ext3
// - flags sampled every clock, samples polled the next clock
// - call blocked by busy level, non-final cycle, reti/enable or priority write, flash programming
// - after reti or enable/priority write one more instruction runs first
// - polling repeats each final cycle; blocked requests are not remembered
// - serial flags never cleared on vectoring; ext0/ext1 cleared only if edge type
// - call pushes pc only and loads vector 0003h + 8 per source
// - reti ends the current level and resumes the interrupted program
// - plain return leaves the in-progress state untouched
// - type 0 is low-level trigger; type 1 sets flag on high then low sample
// - global enable 0 blocks all; otherwise each source gated by its enable
// - timer2 request is overflow flag or external flag; neither cleared on vectoring
// - timer0/timer1 overflow flags cleared when their routine is vectored to
package flviu_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_IE     = 8'h00;
   localparam logic [7:0] ADDR_IPL    = 8'h04;
   localparam logic [7:0] ADDR_IPH    = 8'h08;
   localparam logic [7:0] ADDR_TCTL   = 8'h0C;
   localparam logic [7:0] ADDR_SER    = 8'h10;
   localparam logic [7:0] ADDR_T2CTL  = 8'h14;
   localparam logic [7:0] ADDR_AUX    = 8'h18;
   localparam logic [7:0] ADDR_T2MODE = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IE_GLOBAL  = 7;
   localparam int TC_T1_FLAG = 7;
   localparam int TC_T0_FLAG = 5;
   localparam int TC_X1_FLAG = 3;
   localparam int TC_X1_TYPE = 2;
   localparam int TC_X0_FLAG = 1;
   localparam int TC_X0_TYPE = 0;
   localparam int SER_TX     = 1;
   localparam int SER_RX     = 0;
   localparam int T2_OVF     = 7;
   localparam int T2_EXT     = 6;
   localparam int T2_RXCLK   = 5;
   localparam int T2_TXCLK   = 4;
   localparam int T2_EXEN    = 3;
   localparam int AX_PL3     = 7;
   localparam int AX_EN3     = 6;
   localparam int AX_FL3     = 5;
   localparam int AX_TY3     = 4;
   localparam int AX_PL2     = 3;
   localparam int AX_EN2     = 2;
   localparam int AX_FL2     = 1;
   localparam int AX_TY2     = 0;
   localparam int T2M_UPDOWN = 0;

   // ----------------------------------------------------------------
   // reset values, vectors, bus answers
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_RESET   = 8'h00;
   localparam logic [7:0]  IE_MASK     = 8'hBF;
   localparam logic [7:0]  IPL_MASK    = 8'h3F;
   localparam logic [15:0] VEC_BASE    = 16'h0003;
   localparam logic [15:0] VEC_STEP    = 16'h0008;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   localparam logic [2:0]  LVL_NONE    = 3'h4;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } flviu_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } flviu_axi_rsp_t;

   typedef struct packed {
      logic last_cycle;
      logic reti;
      logic flash_prog;
   } flviu_cpu_t;

   typedef struct packed {
      logic t0_ovf;
      logic t1_ovf;
      logic t2_ovf;
      logic rx_done;
      logic tx_done;
   } flviu_evt_t;

   typedef struct packed {
      logic        call;
      logic [15:0] vector;
      logic [1:0]  level;
      logic [2:0]  source;
   } flviu_call_t;

endpackage

// ### verif/flviu_cpu_model.sv
// cpu sequencer stand-in: two-clock instructions, return on request
// assumes the bench never asks for a return in a cycle that brings a call
`timescale 1ns/100ps
module flviu_cpu_model (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_reti_req,
   output flviu_pkg::flviu_cpu_t o_cpu
);
   logic phase;
   always_ff @(posedge i_clk) begin
      phase <= i_rst ? 1'b0 : ~phase;
   end
   // second clock of each instruction is its polling cycle; a return spans both clocks
   assign o_cpu = '{last_cycle: phase,
                    reti: i_reti_req, flash_prog: 1'b0};
endmodule

// ### verif/test_four_level_vectored_interrupt_unit.sv
// self-checking bench of the interrupt unit: register bus, events, pins, calls
// assumes the cpu model paces instructions; pins idle high
`timescale 1ns/100ps
module test_four_level_vectored_interrupt_unit;
   logic                      I_MCLK = 1'b0;
   logic                      I_SRST = 1'b1;
   logic                      rq     = 1'b0;
   logic [3:0]                pin    = 4'hF;
   logic                      t2p    = 1'b1;
   flviu_pkg::flviu_axi_req_t req    = '0;
   flviu_pkg::flviu_axi_rsp_t rsp;
   flviu_pkg::flviu_cpu_t     cpu;
   flviu_pkg::flviu_evt_t     ev     = '0;
   flviu_pkg::flviu_call_t    cl;
   logic [3:0]                ip;
   int                        fails = 0;
   int                        n_compared = 0;
   always #50 I_MCLK = ~I_MCLK;
   flviu_top dut (.I_MCLK(I_MCLK), .I_SRST(I_SRST), .I_AXI(req), .O_AXI(rsp), .I_CPU(cpu),
      .I_EVT(ev), .I_EXT_REQUEST_PIN_N(pin), .I_T2_EXTERNAL_PIN(t2p), .O_CALL(cl),
      .O_IN_PROGRESS(ip));
   flviu_cpu_model cpu_model (.i_clk(I_MCLK), .i_rst(I_SRST), .i_reti_req(rq), .o_cpu(cpu));
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w, b;
      req.awvalid <= 1'b1; req.wvalid <= 1'b1; req.awaddr <= a;
      req.wdata <= {24'h0000_00, d}; req.wstrb <= 4'hF; req.bready <= 1'b1;
      do begin
         @(negedge I_MCLK);
         aw = rsp.awready; w = rsp.wready; b = rsp.bvalid;
         @(posedge I_MCLK);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end while (!b);
   endtask
   // read and compare: response code above the data
   task automatic rchk(input logic [7:0] a, input logic [33:0] e);
      logic tk, got;
      logic [33:0] d;
      req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
      do begin
         @(negedge I_MCLK);
         tk = rsp.arready; got = rsp.rvalid; d = {rsp.rresp, rsp.rdata};
         @(posedge I_MCLK);
         if (tk) req.arvalid <= 1'b0;
      end while (!got);
      chk(d, e);
   endtask
   task automatic pulse(input flviu_pkg::flviu_evt_t e);
      ev <= e;
      @(posedge I_MCLK);
      ev <= '0;
   endtask
   // a vector of zero means no call may come in the window
   task automatic see_call(input logic [15:0] v, input logic [3:0] p);
      logic hit;
      logic [1:0] lv;
      hit = 1'b0;
      lv = 2'd0;
      // the new call's level is the most urgent one in progress
      for (int j = 3; j >= 0; j--)
         if (p[j]) lv = 2'(j);
      for (int k = 0; k < 24 && !hit; k++) begin
         @(negedge I_MCLK);
         hit = (cl.call === 1'b1);
      end
      chk(hit ? cl.vector : 16'h0000, v);
      if (hit) chk({cl.level, cl.source}, {lv, v[5:3]});
      if (!hit) @(negedge I_MCLK);
      chk(ip, p);
      @(posedge I_MCLK);
   endtask
   // a return fills one whole instruction
   task automatic ret(input logic [3:0] p);
      do @(negedge I_MCLK); while (cpu.last_cycle !== 1'b1);
      @(posedge I_MCLK);
      rq <= 1'b1;
      repeat (2) @(posedge I_MCLK);
      rq <= 1'b0;
      @(negedge I_MCLK);
      chk(ip, p);
      @(posedge I_MCLK);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      rchk(flviu_pkg::ADDR_IE, 34'h0);
      rchk(flviu_pkg::ADDR_AUX, 34'h0);
      rchk(8'h24, {flviu_pkg::RESP_SLVERR, 32'h0000_0000});
      wr(flviu_pkg::ADDR_AUX, 8'hDD);
      rchk(flviu_pkg::ADDR_AUX, 34'h0DD);
      wr(flviu_pkg::ADDR_AUX, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_basic;
      wr(flviu_pkg::ADDR_IE, 8'h82);
      pulse(5'b10000);
      see_call(16'h000B, 4'b1000);
      rchk(flviu_pkg::ADDR_TCTL, 34'h0);
      ret(4'b0000);
      see_call(16'h0000, 4'b0000);
      $display("test basic done");
   endtask
   task automatic t_order;
      wr(flviu_pkg::ADDR_IE, 8'h8A);
      pulse(5'b11000);
      see_call(16'h000B, 4'b1000);
      see_call(16'h0000, 4'b1000);
      ret(4'b0000);
      see_call(16'h001B, 4'b1000);
      ret(4'b0000);
      $display("test order done");
   endtask
   task automatic t_prio;
      wr(flviu_pkg::ADDR_IPH, 8'h08);
      wr(flviu_pkg::ADDR_IPL, 8'h08);
      pulse(5'b10000);
      see_call(16'h000B, 4'b1000);
      pulse(5'b01000);
      see_call(16'h001B, 4'b1001);
      ret(4'b1000);
      ret(4'b0000);
      $display("test prio done");
   endtask
   task automatic t_misc;
      wr(flviu_pkg::ADDR_IE, 8'h12);
      pulse(5'b10000);
      see_call(16'h0000, 4'b0000);
      wr(flviu_pkg::ADDR_IE, 8'h90);
      pulse(5'b00010);
      see_call(16'h0023, 4'b1000);
      rchk(flviu_pkg::ADDR_SER, 34'h1);
      wr(flviu_pkg::ADDR_SER, 8'h00);
      ret(4'b0000);
      $display("test misc done");
   endtask
   task automatic t_edge;
      wr(flviu_pkg::ADDR_AUX, 8'h05);
      wr(flviu_pkg::ADDR_IE, 8'h84);
      pin <= 4'hB;
      see_call(16'h0033, 4'b1000);
      repeat (6) @(posedge I_MCLK);
      pin <= 4'hF;
      rchk(flviu_pkg::ADDR_AUX, 34'h05);
      ret(4'b0000);
      pin <= 4'hD;
      see_call(16'h0013, 4'b1000);
      rchk(flviu_pkg::ADDR_TCTL, 34'h28);
      repeat (2) @(posedge I_MCLK);
      pin <= 4'hF;
      repeat (12) @(posedge I_MCLK);
      rchk(flviu_pkg::ADDR_TCTL, 34'h20);
      ret(4'b0000);
      see_call(16'h0000, 4'b0000);
      wr(flviu_pkg::ADDR_T2CTL, 8'h08);
      t2p <= 1'b0;
      repeat (12) @(posedge I_MCLK);
      t2p <= 1'b1;
      pulse(5'b00100);
      rchk(flviu_pkg::ADDR_T2CTL, 34'hC8);
      $display("test edge done");
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge I_MCLK);
      I_SRST <= 1'b0;
      @(posedge I_MCLK);
      t_regs;
      t_basic;
      t_order;
      t_prio;
      t_misc;
      t_edge;
      results;
   end
   initial begin
      repeat (4000) @(posedge I_MCLK);
      fails++;
      results;
   end
endmodule

// ### verilog/flviu_top.sv
// four-level vectored interrupt unit: flags, priority resolution, call request
// assumes cpu sequencer, timers and serial port run on I_MCLK; pins are asynchronous
`timescale 1ns/100ps
module flviu_top (
   input  wire logic                    I_MCLK,
   input  wire logic                    I_SRST,
   input  wire flviu_pkg::flviu_axi_req_t I_AXI,
   output flviu_pkg::flviu_axi_rsp_t    O_AXI,
   input  wire flviu_pkg::flviu_cpu_t   I_CPU,
   input  wire flviu_pkg::flviu_evt_t   I_EVT,
   input  wire logic [3:0]              I_EXT_REQUEST_PIN_N,
   input  wire logic                    I_T2_EXTERNAL_PIN,
   output flviu_pkg::flviu_call_t       O_CALL,
   output logic [3:0]                   O_IN_PROGRESS
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [1:0] prio_level(input logic hi, input logic lo);
      return {~hi, ~lo};
   endfunction

   function automatic logic [15:0] vector_of(input logic [2:0] src);
      return flviu_pkg::VEC_BASE + flviu_pkg::VEC_STEP * {13'h0000, src};
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0]  aw_addr;
   logic [7:0]  w_data;
   logic        w_lane0;
   logic        aw_got;
   logic        w_got;
   logic        wr_fire;
   logic [7:0]  ie_reg;
   logic [7:0]  ipl_reg;
   logic [7:0]  iph_reg;
   logic [7:0]  t2_ctl;
   logic        updown;
   logic [3:0]  ext_flag;
   logic [3:0]  ext_type;
   logic [3:0]  aux_en;
   logic [3:0]  aux_pl;
   logic        t0_flag;
   logic        t1_flag;
   logic        rx_flag;
   logic        tx_flag;
   logic [3:0]  pin_s1;
   logic [3:0]  pin_s2;
   logic [3:0]  pin_q;
   logic [3:0]  ext_fall;
   logic [2:0]  t2p_sync;
   logic        t2_fall;
   logic [7:0]  req;
   logic [7:0]  en;
   logic [7:0]  plo;
   logic [7:0]  req_sample;
   logic [7:0]  pending;
   logic [2:0]  best_lvl;
   logic [2:0]  win;
   logic [2:0]  active_lvl;
   logic [3:0]  in_prog;
   logic        hold;
   logic        prio_wr;
   logic        blocked;
   logic        call_now;
   logic [7:0]  rd_val;
   logic        rd_ok;
   logic        b_valid;
   logic [1:0]  b_resp;
   logic        r_valid;
   logic [31:0] r_data;
   logic [1:0]  r_resp;

   // ----------------------------------------------------------------
   // bus slave: write address and data taken in either order
   // ----------------------------------------------------------------
   // one driver for the whole response bundle
   assign O_AXI   = '{awready: ~aw_got, wready: ~w_got, bvalid: b_valid, bresp: b_resp,
                      arready: ~r_valid, rvalid: r_valid, rdata: r_data, rresp: r_resp};
   assign wr_fire = aw_got & w_got & ~b_valid;

   function automatic logic wr_hit(input logic [7:0] a);
      return wr_fire && w_lane0 && (aw_addr == a);
   endfunction

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         aw_got  <= 1'b0;
         aw_addr <= 8'h00;
      end else if (I_AXI.awvalid && !aw_got) begin
         aw_got  <= 1'b1;
         aw_addr <= I_AXI.awaddr;
      end else if (b_valid && I_AXI.bready) begin
         aw_got  <= 1'b0;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         w_got   <= 1'b0;
         w_data  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (I_AXI.wvalid && !w_got) begin
         w_got   <= 1'b1;
         w_data  <= I_AXI.wdata[7:0];
         w_lane0 <= I_AXI.wstrb[0];
      end else if (b_valid && I_AXI.bready) begin
         w_got   <= 1'b0;
      end
   end

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 8'h00;
      case (I_AXI.araddr)
         flviu_pkg::ADDR_IE:     rd_val = ie_reg;
         flviu_pkg::ADDR_IPL:    rd_val = ipl_reg;
         flviu_pkg::ADDR_IPH:    rd_val = iph_reg;
         flviu_pkg::ADDR_TCTL:   rd_val = {t1_flag, 1'b0, t0_flag, 1'b0,
                                           ext_flag[1], ext_type[1], ext_flag[0], ext_type[0]};
         flviu_pkg::ADDR_SER:    rd_val = {6'h00, tx_flag, rx_flag};
         flviu_pkg::ADDR_T2CTL:  rd_val = t2_ctl;
         flviu_pkg::ADDR_AUX:    rd_val = {aux_pl[3], aux_en[3], ext_flag[3], ext_type[3],
                                           aux_pl[2], aux_en[2], ext_flag[2], ext_type[2]};
         flviu_pkg::ADDR_T2MODE: rd_val = {7'h00, updown};
         flviu_pkg::ADDR_STATUS: rd_val = {4'h0, in_prog};
         default:                rd_ok  = 1'b0;
      endcase
   end

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= flviu_pkg::ADDR_STATUS);
   endfunction

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         b_valid <= 1'b0;
         b_resp  <= flviu_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         b_valid <= 1'b1;
         b_resp  <= addr_mapped(aw_addr) ? flviu_pkg::RESP_OKAY
                                         : flviu_pkg::RESP_SLVERR;
      end else if (I_AXI.bready) begin
         b_valid <= 1'b0;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         r_valid <= 1'b0;
         r_data  <= 32'h0000_0000;
         r_resp  <= flviu_pkg::RESP_OKAY;
      end else if (I_AXI.arvalid && !r_valid) begin
         r_valid <= 1'b1;
         r_data  <= {24'h00_0000, rd_val};
         r_resp  <= rd_ok ? flviu_pkg::RESP_OKAY : flviu_pkg::RESP_SLVERR;
      end else if (I_AXI.rready) begin
         r_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // enable and priority registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         ie_reg  <= flviu_pkg::REG_RESET;
         ipl_reg <= flviu_pkg::REG_RESET;
         iph_reg <= flviu_pkg::REG_RESET;
      end else begin
         if (wr_hit(flviu_pkg::ADDR_IE))
            ie_reg <= w_data & flviu_pkg::IE_MASK;
         if (wr_hit(flviu_pkg::ADDR_IPL))
            ipl_reg <= w_data & flviu_pkg::IPL_MASK;
         if (wr_hit(flviu_pkg::ADDR_IPH))
            iph_reg <= w_data;
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         ext_type <= 4'h0;
         aux_en   <= 4'h0;
         aux_pl   <= 4'h0;
         updown   <= 1'b0;
      end else begin
         if (wr_hit(flviu_pkg::ADDR_TCTL)) begin
            ext_type[0] <= w_data[flviu_pkg::TC_X0_TYPE];
            ext_type[1] <= w_data[flviu_pkg::TC_X1_TYPE];
         end
         if (wr_hit(flviu_pkg::ADDR_AUX)) begin
            ext_type[2] <= w_data[flviu_pkg::AX_TY2];
            ext_type[3] <= w_data[flviu_pkg::AX_TY3];
            aux_en      <= {w_data[flviu_pkg::AX_EN3], w_data[flviu_pkg::AX_EN2], 2'b00};
            aux_pl      <= {w_data[flviu_pkg::AX_PL3], w_data[flviu_pkg::AX_PL2], 2'b00};
         end
         if (wr_hit(flviu_pkg::ADDR_T2MODE))
            updown <= w_data[flviu_pkg::T2M_UPDOWN];
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         pin_s1   <= 4'hF;
         pin_s2   <= 4'hF;
         pin_q    <= 4'hF;
         t2p_sync <= 3'h7;
      end else begin
         pin_s1   <= I_EXT_REQUEST_PIN_N;
         pin_s2   <= pin_s1;
         pin_q    <= pin_s2;
         t2p_sync <= {t2p_sync[1:0], I_T2_EXTERNAL_PIN};
      end
   end

   assign ext_fall = pin_q & ~pin_s2;
   assign t2_fall  = t2p_sync[2] & ~t2p_sync[1];

   // ----------------------------------------------------------------
   // request flags: hardware set wins over any clear
   // ----------------------------------------------------------------
   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         ext_flag <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (!ext_type[i])
               ext_flag[i] <= ~pin_s2[i];
            else if (ext_fall[i])
               ext_flag[i] <= 1'b1;
            else if (call_now && win == 3'(i == 0 ? 0 : i == 1 ? 2 : i + 4))
               ext_flag[i] <= 1'b0;
            else if (i < 2 && wr_hit(flviu_pkg::ADDR_TCTL))
               ext_flag[i] <= w_data[i == 0 ? flviu_pkg::TC_X0_FLAG : flviu_pkg::TC_X1_FLAG];
            else if (i >= 2 && wr_hit(flviu_pkg::ADDR_AUX))
               ext_flag[i] <= w_data[i == 2 ? flviu_pkg::AX_FL2 : flviu_pkg::AX_FL3];
         end
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         t0_flag <= 1'b0;
         t1_flag <= 1'b0;
      end else begin
         if (I_EVT.t0_ovf)
            t0_flag <= 1'b1;
         else if (call_now && win == 3'd1)
            t0_flag <= 1'b0;
         else if (wr_hit(flviu_pkg::ADDR_TCTL))
            t0_flag <= w_data[flviu_pkg::TC_T0_FLAG];
         if (I_EVT.t1_ovf)
            t1_flag <= 1'b1;
         else if (call_now && win == 3'd3)
            t1_flag <= 1'b0;
         else if (wr_hit(flviu_pkg::ADDR_TCTL))
            t1_flag <= w_data[flviu_pkg::TC_T1_FLAG];
      end
   end

   // serial flags only software clears
   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         rx_flag <= 1'b0;
         tx_flag <= 1'b0;
      end else begin
         rx_flag <= I_EVT.rx_done | (wr_hit(flviu_pkg::ADDR_SER) ?
                                     w_data[flviu_pkg::SER_RX] : rx_flag);
         tx_flag <= I_EVT.tx_done | (wr_hit(flviu_pkg::ADDR_SER) ?
                                     w_data[flviu_pkg::SER_TX] : tx_flag);
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         t2_ctl <= flviu_pkg::REG_RESET;
      end else begin
         if (wr_hit(flviu_pkg::ADDR_T2CTL))
            t2_ctl <= w_data;
         if (I_EVT.t2_ovf && !t2_ctl[flviu_pkg::T2_RXCLK] && !t2_ctl[flviu_pkg::T2_TXCLK])
            t2_ctl[flviu_pkg::T2_OVF] <= 1'b1;
         if (t2_fall && t2_ctl[flviu_pkg::T2_EXEN])
            t2_ctl[flviu_pkg::T2_EXT] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // sampling, polling and resolution
   // ----------------------------------------------------------------
   assign req = {ext_flag[3], ext_flag[2],
                 t2_ctl[flviu_pkg::T2_OVF] | (t2_ctl[flviu_pkg::T2_EXT] & ~updown),
                 rx_flag | tx_flag, t1_flag, ext_flag[1], t0_flag, ext_flag[0]};
   assign en  = {aux_en[3], aux_en[2], ie_reg[5:0]};
   assign plo = {aux_pl[3], aux_pl[2], ipl_reg[5:0]};

   always_ff @(posedge I_MCLK) begin
      if (I_SRST)
         req_sample <= 8'h00;
      else
         req_sample <= req & en;
   end

   assign pending = req_sample & {8{ie_reg[flviu_pkg::IE_GLOBAL]}};

   always_comb begin
      best_lvl = flviu_pkg::LVL_NONE;
      win      = 3'd0;
      for (int s = 0; s < 8; s++) begin
         // strict compare keeps the earliest source among equals
         if (pending[s] && {1'b0, prio_level(iph_reg[s], plo[s])} < best_lvl) begin
            best_lvl = {1'b0, prio_level(iph_reg[s], plo[s])};
            win      = 3'(s);
         end
      end
   end

   always_comb begin
      active_lvl = flviu_pkg::LVL_NONE;
      for (int l = 3; l >= 0; l--) begin
         if (in_prog[l])
            active_lvl = 3'(l);
      end
   end

   assign prio_wr = wr_hit(flviu_pkg::ADDR_IE) | wr_hit(flviu_pkg::ADDR_IPL) |
                    wr_hit(flviu_pkg::ADDR_IPH) | wr_hit(flviu_pkg::ADDR_AUX);

   // a blocked request leaves no trace; next final cycle polls afresh
   assign blocked  = (best_lvl >= active_lvl) | ~I_CPU.last_cycle | hold |
                     I_CPU.reti | prio_wr | I_CPU.flash_prog;
   assign call_now = (best_lvl != flviu_pkg::LVL_NONE) & ~blocked;

   // hold spans the rest of a reti or enable/priority-writing instruction
   always_ff @(posedge I_MCLK) begin
      if (I_SRST)
         hold <= 1'b0;
      else if (I_CPU.last_cycle)
         hold <= 1'b0;
      else if (I_CPU.reti || prio_wr)
         hold <= 1'b1;
   end

   // only reti clears in-progress state; a plain return is invisible here
   always_ff @(posedge I_MCLK) begin
      if (I_SRST)
         in_prog <= 4'h0;
      else if (call_now)
         in_prog[best_lvl[1:0]] <= 1'b1;
      else if (I_CPU.reti && I_CPU.last_cycle && active_lvl != flviu_pkg::LVL_NONE)
         in_prog[active_lvl[1:0]] <= 1'b0;
   end

   assign O_IN_PROGRESS = in_prog;

   always_ff @(posedge I_MCLK) begin
      if (I_SRST) begin
         O_CALL <= '0;
      end else begin
         O_CALL.call <= call_now;
         if (call_now) begin
            O_CALL.vector <= vector_of(win);
            O_CALL.level  <= best_lvl[1:0];
            O_CALL.source <= win;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SRST);

   sequence s_reti_mid;
      I_CPU.reti && !I_CPU.last_cycle;
   endsequence

   sequence s_end_of_reti;
      s_reti_mid ##1 I_CPU.last_cycle;
   endsequence

   a_t2_overflow_set: assert property (
      (I_EVT.t2_ovf && !t2_ctl[flviu_pkg::T2_RXCLK] && !t2_ctl[flviu_pkg::T2_TXCLK])
      |=> t2_ctl[flviu_pkg::T2_OVF])
      else $error("timer2 overflow flag not set");

   a_t2_ext_set: assert property (
      (t2_fall && t2_ctl[flviu_pkg::T2_EXEN]) |=> t2_ctl[flviu_pkg::T2_EXT])
      else $error("timer2 external flag not set");

   a_ext2_edge_clear: assert property (
      (call_now && win == 3'd6 && ext_type[2] && !ext_fall[2]) |=> !ext_flag[2])
      else $error("ext2 edge flag survived vectoring");

   a_global_gate: assert property (
      !ie_reg[flviu_pkg::IE_GLOBAL] |-> ##1 !O_CALL.call)
      else $error("call issued with global enable off");

   a_call_final_only: assert property (
      call_now |-> I_CPU.last_cycle && !I_CPU.flash_prog && !prio_wr)
      else $error("call outside a permitted final cycle");

   a_reti_one_more: assert property (
      s_end_of_reti |-> !call_now)
      else $error("vectored right after reti");

   a_preempt_strict: assert property (
      call_now |-> best_lvl < active_lvl)
      else $error("pre-empted by equal or lower level");

   a_vector_value: assert property (
      call_now |=> O_CALL.call && O_CALL.vector == vector_of($past(win)))
      else $error("wrong vector on call");

   a_poll_sample: assert property (
      call_now |-> req_sample[win] && (req_sample == $past(req & en)))
      else $error("call without a sampled flag");

   a_t0_clear: assert property (
      (call_now && win == 3'd1 && !I_EVT.t0_ovf) |=> !t0_flag)
      else $error("timer0 flag not cleared on vectoring");

   a_reti_level_end: assert property (
      (I_CPU.reti && I_CPU.last_cycle && in_prog[0])
      |=> !in_prog[0] ##1 !in_prog[0] || $past(call_now))
      else $error("reti did not end top level");

   a_serial_kept: assert property (
      (call_now && win == 3'd4 && !wr_hit(flviu_pkg::ADDR_SER)) |=> rx_flag == $past(rx_flag)
      || $past(I_EVT.rx_done))
      else $error("serial flag cleared by vectoring");

endmodule
